// ### core/eifd_core.sv
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module eifd_core
    import eifd_pkg::*;
#(
    parameter int NUM_EV = 4,
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int FILT_LEN = FILTER_TICKS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [NUM_EV-1:0] eventIn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [DATA_W-1:0] rdData,
    output logic [FUNC_COUNT-1:0] cmdPulse,
    output logic [FUNC_COUNT-1:0] cmdLevel,
    output logic runControl,
    output logic seqStartPulse,
    output logic seqResetPulse,
    output logic progEndClear,
    output logic [SP_IDX_W-1:0] activeSpIndex,
    output logic [SP_W-1:0] activeSpValue
);

    typedef struct packed {
        logic [TICK_CNT_W-1:0] tickCnt;
        logic [NUM_EV-1:0][FILT_CNT_W-1:0] filtCnt;
        logic [NUM_EV-1:0] filt;
        logic [NUM_EV-1:0] prevFilt;
        logic [NUM_EV-1:0][FUNC_W-1:0] assign_;
        logic [CTRL_W-1:0] ctrl;
        logic [FILT_CNT_W-1:0] settleCnt;
        logic primed;
        logic runActive;
        logic [SP_IDX_W-1:0] spBits;
        logic [FUNC_COUNT-1:0] pulse;
        logic [FUNC_COUNT-1:0] level;
        logic seqStart;
        logic seqReset;
        logic rdSpSel;
        logic [DATA_W-1:0] rdData;
    } eifd_state_t;

    eifd_state_t state_reg;
    eifd_state_t state_next;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic isEdgeFunc(input logic [FUNC_W-1:0] code);
        unique case (code)
            FN_HAND, FN_SEQ_LAUNCH, FN_INVERT,
            FN_EDIT_LOCK, FN_REMOTE_GATE: isEdgeFunc = 1'b0;
            FN_NONE: isEdgeFunc = 1'b0;
            default: isEdgeFunc = (code < FUNC_COUNT[FUNC_W-1:0]);
        endcase
    endfunction

    function automatic logic isAssigned(
        input logic [NUM_EV-1:0][FUNC_W-1:0] table_,
        input logic [FUNC_W-1:0] code);
        isAssigned = 1'b0;
        for (int i = 0; i < NUM_EV; i++) begin
            if (table_[i] == code) begin
                isAssigned = 1'b1;
            end
        end
    endfunction

    function automatic logic isRegAddr(input logic [ADDR_W-1:0] a);
        isRegAddr = (a[1:0] == 2'h0);
    endfunction

    // ****************************************
    // Combinational next state
    // ****************************************
    logic [NUM_EV-1:0] rawIn;
    logic [FUNC_COUNT-1:0] fnLevel;
    logic [FUNC_COUNT-1:0] fnChange;
    logic [FUNC_COUNT-1:0] keyPulse;
    logic tick;
    logic powerUpEdge;
    logic spAnyAssigned;
    logic keySelOk;
    logic [SP_IDX_W-1:0] spIndex;
    logic spWrite;
    logic [SP_IDX_W-1:0] spWrAddr;
    logic [SP_IDX_W-1:0] spRdAddr;
    logic [SP_W-1:0] spBusData;
    logic [SP_W-1:0] spActiveData;
    logic [FUNC_W-1:0] newCode;
    logic [FUNC_W-1:0] keyCode;
    logic [DATA_W-1:0] statusWord;

    always_comb begin
        state_next = state_reg;
        newCode = wrData[FUNC_W-1:0];
        keyCode = wrData[FUNC_W-1:0];
        keyPulse = '0;
        fnLevel = '0;
        fnChange = '0;
        statusWord = '0;
        spWrite = 1'b0;
        spWrAddr = addr[SP_IDX_W+1:2];
        spRdAddr = addr[SP_IDX_W+1:2];

        // Cable-only power reads every input as OFF
        rawIn = state_reg.ctrl[CTRL_CABLE_ONLY] ? '0 : eventIn;

        // 1 ms sample tick
        tick = (state_reg.tickCnt == TICK_CNT_W'(TICK_LEN - 1));
        state_next.tickCnt = tick ? '0 : state_reg.tickCnt + 1'b1;

        // Per-input change filter
        for (int i = 0; i < NUM_EV; i++) begin
            if (tick) begin
                if (rawIn[i] == state_reg.filt[i]) begin
                    state_next.filtCnt[i] = '0;
                end else if (state_reg.filtCnt[i] ==
                             FILT_CNT_W'(FILT_LEN - 1)) begin
                    state_next.filt[i] = rawIn[i];
                    state_next.filtCnt[i] = '0;
                end else begin
                    state_next.filtCnt[i] = state_reg.filtCnt[i] + 1'b1;
                end
            end
        end
        state_next.prevFilt = state_reg.filt;

        // Power-up edge once the first filter window has passed
        powerUpEdge = 1'b0;
        if (!state_reg.primed && tick) begin
            if (state_reg.settleCnt == FILT_CNT_W'(FILT_LEN)) begin
                state_next.primed = 1'b1;
                powerUpEdge = 1'b1;
            end else begin
                state_next.settleCnt = state_reg.settleCnt + 1'b1;
            end
        end

        // Gather levels and changes per function
        for (int i = 0; i < NUM_EV; i++) begin
            for (int f = 1; f < FUNC_COUNT; f++) begin
                if (state_reg.assign_[i] == FUNC_W'(f)) begin
                    fnLevel[f] = fnLevel[f] | state_reg.filt[i];
                    fnChange[f] = fnChange[f] |
                        (state_reg.filt[i] != state_reg.prevFilt[i]);
                end
            end
        end

        // Function key requests
        if (wrStrobe && addr == ADDR_KEY && keyCode < FUNC_W'(FUNC_COUNT)
            && !isAssigned(state_reg.assign_, keyCode)) begin
            keyPulse[keyCode] = 1'b1;
        end

        // Edge functions: pulses only on change, key request or power-up
        for (int f = 0; f < FUNC_COUNT; f++) begin
            state_next.pulse[f] = 1'b0;
            state_next.level[f] = 1'b0;
            if (isEdgeFunc(FUNC_W'(f))) begin
                state_next.pulse[f] = fnChange[f] | keyPulse[f] |
                    (powerUpEdge & isAssigned(state_reg.assign_,
                                              FUNC_W'(f)));
                state_next.level[f] = fnLevel[f];
            end else begin
                state_next.level[f] = fnLevel[f];
            end
        end
        if (state_reg.ctrl[CTRL_HEAT_COOL]) begin
            state_next.pulse[FN_PART_AT] = 1'b0;
        end
        if (!state_reg.ctrl[CTRL_PATTERN_ON]) begin
            state_next.level[FN_SEQ_LAUNCH] = 1'b0;
        end

        // Run state: OFF runs for run/stop, reversed for stop/run
        if (state_next.pulse[FN_RUN_STOP]) begin
            state_next.runActive = fnChange[FN_RUN_STOP] | powerUpEdge ?
                !fnLevel[FN_RUN_STOP] : !state_reg.runActive;
        end
        if (state_next.pulse[FN_STOP_RUN]) begin
            state_next.runActive = fnChange[FN_STOP_RUN] | powerUpEdge ?
                fnLevel[FN_STOP_RUN] : !state_reg.runActive;
        end

        // Sequence launch: start on ON, reset and stop on OFF
        state_next.seqStart = 1'b0;
        state_next.seqReset = 1'b0;
        if (state_reg.ctrl[CTRL_PATTERN_ON] && fnChange[FN_SEQ_LAUNCH]) begin
            if (fnLevel[FN_SEQ_LAUNCH]) begin
                state_next.seqStart = 1'b1;
            end else begin
                state_next.seqReset = 1'b1;
                state_next.runActive = 1'b0;
            end
        end

        // Set point select bits follow their edges
        if (state_next.pulse[FN_SP_BIT0]) begin
            state_next.spBits[0] = fnLevel[FN_SP_BIT0];
        end
        if (state_next.pulse[FN_SP_BIT1]) begin
            state_next.spBits[1] = fnLevel[FN_SP_BIT1];
        end
        if (state_next.pulse[FN_SP_BIT2]) begin
            state_next.spBits[2] = fnLevel[FN_SP_BIT2];
        end
        for (int b = 0; b < SP_IDX_W; b++) begin
            if (!isAssigned(state_reg.assign_,
                            FUNC_W'(int'(FN_SP_BIT0) + b))) begin
                state_next.spBits[b] = 1'b0;
            end
        end

        // Register writes
        if (wrStrobe && isRegAddr(addr)) begin
            if (addr <= ADDR_ASSIGN3 && int'(addr[3:2]) < NUM_EV) begin
                if (newCode >= FUNC_W'(FUNC_COUNT)) begin
                    newCode = FN_NONE;
                end
                if (newCode == FN_REMOTE_GATE &&
                    (!state_reg.ctrl[CTRL_COMMS] ||
                     state_reg.ctrl[CTRL_WORK_BIT])) begin
                    newCode = FN_NONE;
                end
                state_next.assign_[addr[3:2]] = newCode;
            end else if (addr == ADDR_CTRL) begin
                state_next.ctrl = wrData[CTRL_W-1:0];
            end else if (addr >= ADDR_SP_BASE && addr <= ADDR_SP_LAST) begin
                spWrite = 1'b1;
            end
        end

        // Register reads, one cycle later
        state_next.rdSpSel = 1'b0;
        state_next.rdData = '0;
        statusWord[STAT_FILT_LO +: NUM_EV] = state_reg.filt;
        statusWord[STAT_SP_LO +: SP_IDX_W] = spIndex;
        statusWord[STAT_RUN] = state_reg.runActive;
        statusWord[STAT_KEY_SEL_OK] = keySelOk;
        statusWord[STAT_REMOTE_OK] = state_reg.level[FN_REMOTE_GATE];
        statusWord[STAT_PRIMED] = state_reg.primed;
        if (rdStrobe && isRegAddr(addr)) begin
            if (addr <= ADDR_ASSIGN3 && int'(addr[3:2]) < NUM_EV) begin
                state_next.rdData[FUNC_W-1:0] = state_reg.assign_[addr[3:2]];
            end else if (addr == ADDR_CTRL) begin
                state_next.rdData[CTRL_W-1:0] = state_reg.ctrl;
            end else if (addr == ADDR_STATUS) begin
                state_next.rdData = statusWord;
            end else if (addr >= ADDR_SP_BASE && addr <= ADDR_SP_LAST) begin
                state_next.rdSpSel = 1'b1;
            end
        end
    end

    // ****************************************
    // Active set point choice
    // ****************************************
    assign spAnyAssigned = isAssigned(state_reg.assign_, FN_SP_BIT0) |
        isAssigned(state_reg.assign_, FN_SP_BIT1) |
        isAssigned(state_reg.assign_, FN_SP_BIT2);
    assign keySelOk = !state_reg.ctrl[CTRL_SP_COUNT_OFF] &&
        !spAnyAssigned;
    assign spIndex = keySelOk ?
        state_reg.ctrl[CTRL_KEY_SEL_LO +: SP_IDX_W] :
        state_reg.spBits;

    eifd_sp_mem #(
        .WIDTH(SP_W),
        .DEPTH(SP_COUNT),
        .AW(SP_IDX_W)
    ) u_sp_mem (
        .clk(clk),
        .reset(reset),
        .wrEn(spWrite),
        .wrAddr(spWrAddr),
        .wrData(wrData[SP_W-1:0]),
        .busAddr(spRdAddr),
        .busData(spBusData),
        .activeAddr(spIndex),
        .activeData(spActiveData)
    );

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.ctrl <= CTRL_RESET;
            state_reg.runActive <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdData = state_reg.rdSpSel ?
        {{(DATA_W - SP_W){1'b0}}, spBusData} : state_reg.rdData;
    assign cmdPulse = state_reg.pulse;
    assign cmdLevel = state_reg.level;
    assign runControl = state_reg.runActive;
    assign seqStartPulse = state_reg.seqStart;
    assign seqResetPulse = state_reg.seqReset;
    assign progEndClear = state_reg.seqReset;
    assign activeSpIndex = spIndex;
    assign activeSpValue = spActiveData;
endmodule // eifd_core
`default_nettype wire

// ### core/eifd_pkg.sv
package eifd_pkg;

    // ****************************************
    // Function codes
    // ****************************************
    localparam int FUNC_W = 5;
    localparam int FUNC_COUNT = 17;
    localparam logic [4:0] FN_NONE = 5'h00;
    localparam logic [4:0] FN_RUN_STOP = 5'h01;
    localparam logic [4:0] FN_HAND = 5'h02;
    localparam logic [4:0] FN_SEQ_LAUNCH = 5'h03;
    localparam logic [4:0] FN_INVERT = 5'h04;
    localparam logic [4:0] FN_FULL_AT = 5'h05;
    localparam logic [4:0] FN_PART_AT = 5'h06;
    localparam logic [4:0] FN_EDIT_LOCK = 5'h07;
    localparam logic [4:0] FN_REMOTE_GATE = 5'h08;
    localparam logic [4:0] FN_ALARM_CLR = 5'h09;
    localparam logic [4:0] FN_SP_BIT0 = 5'h0A;
    localparam logic [4:0] FN_SP_BIT1 = 5'h0B;
    localparam logic [4:0] FN_SP_BIT2 = 5'h0C;
    localparam logic [4:0] FN_STOP_RUN = 5'h0D;
    localparam logic [4:0] FN_ADAPT = 5'h0E;
    localparam logic [4:0] FN_FILTER = 5'h0F;
    localparam logic [4:0] FN_COOLANT = 5'h10;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_ASSIGN0 = 8'h00;
    localparam logic [7:0] ADDR_ASSIGN3 = 8'h0C;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_KEY = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_SP_BASE = 8'h20;
    localparam logic [7:0] ADDR_SP_LAST = 8'h3C;

    // Control register fields
    localparam int CTRL_PATTERN_ON = 0;
    localparam int CTRL_HEAT_COOL = 1;
    localparam int CTRL_COMMS = 2;
    localparam int CTRL_WORK_BIT = 3;
    localparam int CTRL_CABLE_ONLY = 4;
    localparam int CTRL_SP_COUNT_OFF = 5;
    localparam int CTRL_KEY_SEL_LO = 8;
    localparam int CTRL_W = 11;
    localparam logic [10:0] CTRL_RESET = 11'h024;

    // Status register fields
    localparam int STAT_FILT_LO = 0;
    localparam int STAT_SP_LO = 8;
    localparam int STAT_RUN = 12;
    localparam int STAT_KEY_SEL_OK = 13;
    localparam int STAT_REMOTE_OK = 14;
    localparam int STAT_PRIMED = 15;

    // ****************************************
    // Set points and timing
    // ****************************************
    localparam int SP_COUNT = 8;
    localparam int SP_IDX_W = 3;
    localparam int SP_W = 16;
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int FILTER_MS = 50;
    localparam int FILTER_TICKS = (FILTER_MS * 1000) / TICK_US;
    localparam int FILT_CNT_W = 8;
    localparam int TICK_CNT_W = 20;

endpackage

// ### core/eifd_sp_mem.sv
`timescale 1ns/10ps
`default_nettype none
module eifd_sp_mem
    import eifd_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] busAddr,
    output logic [WIDTH-1:0] busData,
    input wire logic [AW-1:0] activeAddr,
    output logic [WIDTH-1:0] activeData
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0] busData;
        logic [WIDTH-1:0] activeData;
    } eifd_mem_t;

    eifd_mem_t state_reg;
    eifd_mem_t state_next;

    // ****************************************
    // Storage with registered read ports
    // ****************************************
    always_comb begin
        state_next = state_reg;
        if (wrEn) begin
            state_next.words[wrAddr] = wrData;
        end
        state_next.busData = state_reg.words[busAddr];
        state_next.activeData = state_reg.words[activeAddr];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busData = state_reg.busData;
    assign activeData = state_reg.activeData;
endmodule // eifd_sp_mem
`default_nettype wire

// ### sim/eifd_contacts.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Dry contacts on the event inputs
// ****
module eifd_contacts #(
    parameter int NUM_EV = 4,
    parameter int HOLD = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [NUM_EV-1:0] want,
    input wire logic [NUM_EV-1:0] glitch,
    output logic [NUM_EV-1:0] contact
);
    logic [NUM_EV-1:0] levelReg;
    int heldCnt [NUM_EV];
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_EV; i++) begin
            if (reset) begin
                levelReg[i] <= 1'b0;
                heldCnt[i] <= HOLD;
            end else if (want[i] != levelReg[i] && heldCnt[i] >= HOLD) begin
                levelReg[i] <= want[i];
                heldCnt[i] <= 0;
            end else if (heldCnt[i] < HOLD) begin
                heldCnt[i] <= heldCnt[i] + 1;
            end
        end
    end
    // Short bounce only when a scenario asks for it
    assign contact = levelReg ^ glitch;
endmodule // eifd_contacts
`default_nettype wire

// ### sim/eifd_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module eifd_core_bench;
    import eifd_pkg::*;
    localparam int TL = 4;
    localparam int FL = 3;
    localparam int SETTLE = 32;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] want = '0;
    logic [3:0] glitch = '0;
    logic [3:0] eventIn;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wrData = '0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [DATA_W-1:0] rdData;
    logic [FUNC_COUNT-1:0] cmdPulse;
    logic [FUNC_COUNT-1:0] cmdLevel;
    logic runControl;
    logic seqStartPulse;
    logic seqResetPulse;
    logic [SP_IDX_W-1:0] activeSpIndex;
    logic [SP_W-1:0] activeSpValue;
    logic [3:0] v;
    int nFail = 0;
    int totalChecks = 0;
    int seed = 38;
    int edges = 0;
    int cnt [FUNC_COUNT+2];
    int spModel [SP_COUNT];
    always #2 clk = ~clk;
    eifd_contacts #(.NUM_EV(4), .HOLD((FL + 1) * TL)) contacts_u (
        .clk(clk), .reset(reset), .want(want), .glitch(glitch),
        .contact(eventIn));
    eifd_core #(.NUM_EV(4), .TICK_LEN(TL), .FILT_LEN(FL)) dut_u (
        .clk(clk), .reset(reset), .eventIn(eventIn), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .cmdPulse(cmdPulse), .cmdLevel(cmdLevel),
        .runControl(runControl), .seqStartPulse(seqStartPulse),
        .seqResetPulse(seqResetPulse), .progEndClear(),
        .activeSpIndex(activeSpIndex), .activeSpValue(activeSpValue));
    // ****
    // Pulse counters and bus tasks
    // ****
    // Count on the falling edge, clear of the launching edge
    always @(negedge clk) begin
        for (int i = 0; i < FUNC_COUNT; i++) begin
            if (cmdPulse[i] === 1'b1) cnt[i]++;
        end
        if (seqStartPulse === 1'b1) cnt[FUNC_COUNT]++;
        if (seqResetPulse === 1'b1) cnt[FUNC_COUNT+1]++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        check(rdData & m, e);
    endtask
    task automatic asg(input int ch, input logic [4:0] code);
        wr(ADDR_ASSIGN0 + 8'(4 * ch), {27'h0, code});
    endtask
    task automatic settle();
        repeat (SETTLE) @(posedge clk);
        #1;
    endtask
    task automatic setIn(input logic [3:0] w);
        if (w[0] !== want[0]) edges++;
        @(posedge clk);
        want <= w;
        settle();
    endtask
    task automatic clr();
        foreach (cnt[i]) cnt[i] = 0;
        edges = 0;
    endtask
    task automatic results();
        if (nFail == 0 && totalChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        results();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        asg(0, FN_ALARM_CLR);
        rd(ADDR_CTRL, {21'h0, CTRL_RESET}, 32'h7FF);
        settle();
        check(cnt[FN_ALARM_CLR], 1);
        for (int i = 0; i < SP_COUNT; i++) begin
            spModel[i] = $random(seed) & 32'hFFFF;
            wr(ADDR_SP_BASE + 8'(4 * i), spModel[i]);
        end
        for (int i = 0; i < SP_COUNT; i++) begin
            rd(ADDR_SP_BASE + 8'(4 * i), spModel[i], 32'hFFFF);
        end
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CTRL, k == 0 ? 32'h20 : (k == 1 ? 32'h24 : 32'h2C));
            asg(3, FN_REMOTE_GATE);
            rd(ADDR_ASSIGN3, k == 1 ? 32'h8 : 32'h0, 32'h1F);
        end
        asg(1, 5'h11);
        rd(ADDR_ASSIGN0 + 8'h04, 32'h0, 32'h1F);
        wr(ADDR_CTRL, 32'h004);
        asg(1, FN_HAND);
        asg(2, FN_SP_BIT0);
        asg(3, FN_SP_BIT2);
        clr();
        for (int n = 0; n < 8; n++) begin
            v = 4'($random(seed));
            setIn(v);
            check(cmdLevel[FN_HAND], v[1]);
            check(activeSpIndex, {v[3], 1'b0, v[2]});
            check(activeSpValue, spModel[{v[3], 1'b0, v[2]}]);
        end
        setIn(4'h2);
        check(cnt[FN_ALARM_CLR], edges);
        check(cnt[FN_HAND], 0);
        rd(ADDR_STATUS, 32'h0, 32'h2000);
        wr(ADDR_CTRL, 32'h014);
        settle();
        check(cmdLevel[FN_HAND], 0);
        rd(ADDR_STATUS, 32'h0, 32'hF);
        wr(ADDR_CTRL, 32'h004);
        setIn(4'h0);
        @(posedge clk);
        glitch <= 4'h2;
        repeat (8) @(posedge clk);
        glitch <= 4'h0;
        settle();
        check(cmdLevel[FN_HAND], 0);
        asg(2, FN_NONE);
        asg(3, FN_NONE);
        for (int k = 0; k < SP_COUNT; k++) begin
            wr(ADDR_CTRL, 32'h004 | (k << 8));
            repeat (3) @(posedge clk);
            #1;
            check(activeSpIndex, k);
            check(activeSpValue, spModel[k]);
        end
        rd(ADDR_STATUS, 32'h2000, 32'h2000);
        wr(ADDR_CTRL, 32'h724);
        rd(ADDR_STATUS, 32'h0, 32'h2700);
        wr(ADDR_CTRL, 32'h004);
        asg(1, FN_SEQ_LAUNCH);
        clr();
        setIn(4'h2);
        check(cnt[FUNC_COUNT], 0);
        setIn(4'h0);
        wr(ADDR_CTRL, 32'h005);
        setIn(4'h2);
        check(cnt[FUNC_COUNT], 1);
        setIn(4'h0);
        check(cnt[FUNC_COUNT+1], 1);
        check(runControl, 0);
        for (int k = 0; k < 2; k++) begin
            asg(1, k == 0 ? FN_RUN_STOP : FN_STOP_RUN);
            setIn(4'h2);
            check(runControl, k);
            setIn(4'h0);
            check(runControl, 1 - k);
        end
        asg(1, FN_PART_AT);
        clr();
        wr(ADDR_CTRL, 32'h006);
        setIn(4'h2);
        setIn(4'h0);
        check(cnt[FN_PART_AT], 0);
        wr(ADDR_CTRL, 32'h004);
        setIn(4'h2);
        check(cnt[FN_PART_AT], 1);
        clr();
        wr(ADDR_KEY, FN_ALARM_CLR);
        wr(ADDR_KEY, FN_ADAPT);
        repeat (4) @(posedge clk);
        check(cnt[FN_ALARM_CLR], 0);
        check(cnt[FN_ADAPT], 1);
        results();
    end
endmodule // eifd_core_bench
`default_nettype wire

// ### sim/eifd_core_chk.sv
`timescale 1ns/10ps
`default_nettype none
module eifd_core_chk
    import eifd_pkg::*;
#(
    parameter int NUM_EV = 4,
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int FILT_LEN = FILTER_TICKS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [NUM_EV-1:0] eventIn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [DATA_W-1:0] rdData,
    input wire logic [FUNC_COUNT-1:0] cmdPulse,
    input wire logic [FUNC_COUNT-1:0] cmdLevel,
    input wire logic runControl,
    input wire logic seqStartPulse,
    input wire logic seqResetPulse,
    input wire logic progEndClear,
    input wire logic [SP_IDX_W-1:0] activeSpIndex,
    input wire logic [SP_W-1:0] activeSpValue
);
    // Level detected function codes
    localparam logic [16:0] LVL_MASK = 17'h0019C;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    pulse_one_cycle_a: assert property (
        |cmdPulse |=> (cmdPulse & $past(cmdPulse)) == '0)
        else $error("command pulse longer than one cycle");
    level_fn_quiet_a: assert property (
        (cmdPulse & LVL_MASK) == '0)
        else $error("level function produced a pulse");
    reset_clears_a: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> cmdLevel == '0 && cmdPulse == '0)
        else $error("outputs active under reset");
    filter_hold_a: assert property (
        $fell(reset) |-> (cmdLevel == '0) [*8])
        else $error("filtered level on too soon after reset");
    alarm_edge_a: assert property (
        $changed(cmdLevel[FN_ALARM_CLR]) |-> cmdPulse[FN_ALARM_CLR])
        else $error("edge function change without pulse");
    sp_bit_index_a: assert property (
        cmdPulse[FN_SP_BIT0] |-> ##[0:2]
        activeSpIndex[0] == cmdLevel[FN_SP_BIT0])
        else $error("select bit not reflected in index");
    seq_start_a: assert property (
        seqStartPulse |-> cmdLevel[FN_SEQ_LAUNCH])
        else $error("sequence start without launch level");
    seq_reset_stop_a: assert property (
        seqResetPulse |-> ##[0:2] !runControl)
        else $error("sequence reset did not stop control");
    prog_end_clear_a: assert property (
        seqResetPulse |-> progEndClear)
        else $error("sequence reset did not clear end output");
    unmapped_read_a: assert property (
        rdStrobe && addr > ADDR_SP_LAST |=> rdData == '0)
        else $error("unmapped read returned data");
    read_release_a: assert property (
        $past(rdStrobe, 2) && !$past(rdStrobe) |-> rdData == '0)
        else $error("read data stood longer than one cycle");
    cover property (cmdPulse[FN_ALARM_CLR]);
    cover property (seqStartPulse);
    cover property (seqResetPulse);
endmodule // eifd_core_chk
bind eifd_core eifd_core_chk #(.NUM_EV(NUM_EV), .TICK_LEN(TICK_LEN),
    .FILT_LEN(FILT_LEN)) chk_u (.clk(clk), .reset(reset), .eventIn(eventIn),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .cmdPulse(cmdPulse), .cmdLevel(cmdLevel),
    .runControl(runControl), .seqStartPulse(seqStartPulse),
    .seqResetPulse(seqResetPulse), .progEndClear(progEndClear),
    .activeSpIndex(activeSpIndex), .activeSpValue(activeSpValue));
`default_nettype wire
